// File: mbxr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbxr_master_model (
  // Clock
  input  wire logic               clk_sys,
  // Reply stream and pacing
  input  wire mbxr_pkg::mbxr_tx_t tx,
  input  wire logic               slow,
  output logic                    tx_ready
);
  import mbxr_pkg::*;
  logic [7:0] rx_q[$];
  logic       last_q[$];
  logic       phase;
  initial begin
    phase = 1'b0;
    tx_ready = 1'b1;
  end
  // Slow mode is ready every other cycle, so the reply must hold while stalled
  always @(negedge clk_sys) begin
    phase <= ~phase;
    tx_ready <= ~slow | phase;
  end
  // Bytes kept in arrival order, each with its last flag; no field is decoded here
  always @(posedge clk_sys) begin
    if (tx.valid && tx_ready) begin
      rx_q.push_back(tx.data);
      last_q.push_back(tx.last);
    end
  end
endmodule
`default_nettype wire

// File: mbxr_pkg.sv
package mbxr_pkg;

  // Exception response layout
  localparam logic [7:0] MBXR_EXC_FLAG     = 8'h80;
  localparam logic [7:0] MBXR_EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] MBXR_EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] MBXR_EXC_ILL_VAL  = 8'h03;
  localparam logic [7:0] MBXR_EXC_DEV_FAIL = 8'h04;

  // Frame check seed and polynomial (reflected)
  localparam logic [15:0] MBXR_CRC_SEED = 16'hFFFF;
  localparam logic [15:0] MBXR_CRC_POLY = 16'hA001;

  // Supported operations
  localparam logic [7:0] MBXR_FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] MBXR_FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] MBXR_FC_WRITE_MANY = 8'h10;

  // Documented register number to wire address offset
  localparam logic [15:0] MBXR_REG_OFFSET = 16'h0001;

  // Float word order modes
  localparam logic [1:0] MBXR_ORD_ABCD = 2'h0;
  localparam logic [1:0] MBXR_ORD_CDAB = 2'h1;
  localparam logic [1:0] MBXR_ORD_BADC = 2'h2;
  localparam logic [1:0] MBXR_ORD_DCBA = 2'h3;

  // Decoded request presented by the frame parser
  typedef struct packed {
    logic [7:0]  slave_addr;
    logic [7:0]  func;
    logic [15:0] start_addr;
    logic [15:0] count;
    logic        len_bad;
    logic        value_bad;
  } mbxr_req_t;

  // Outgoing byte
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } mbxr_tx_t;

endpackage

// File: mbxr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Rejected request answered with function code plus 80h, then one exception byte.
// - Unsupported function code gives exception 01.
// - Register address outside permitted range gives exception 02.
// - Bad implied length or excessive register count gives exception 03.
// - Any other rejection, such as out-of-limit write value, gives exception 04.
// - Multi-byte values go most significant byte first by default.
// - A setting changes the byte order of a transmitted float.
// - Documented register N is carried on the wire as N minus one.
// - Frame check starts with both bytes all ones.
module mbxr_top #(
  parameter logic [15:0] MAX_ADDR  = 16'h0FFF,
  parameter logic [15:0] MAX_COUNT = 16'h007D
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Request from the frame parser
  input  wire logic             req_valid,
  input  wire mbxr_pkg::mbxr_req_t req,
  input  wire logic [7:0]       own_addr,
  // Float to send and its order setting
  input  wire logic             float_valid,
  input  wire logic [31:0]      float_value,
  input  wire logic [1:0]       float_order,
  // Register number translation
  input  wire logic [15:0]      doc_reg_num,
  output logic [15:0]           wire_reg_addr,
  // Byte stream towards the serial line
  input  wire logic             tx_ready,
  output mbxr_pkg::mbxr_tx_t    tx,
  output logic                  busy,
  output logic                  req_accepted
);
  import mbxr_pkg::*;

  typedef enum logic [2:0] {
    MBXR_IDLE, MBXR_ADDR, MBXR_FUNC, MBXR_CODE, MBXR_CRCL, MBXR_CRCH, MBXR_FLT
  } mbxr_state_t;

  initial begin
    if (MAX_COUNT == 16'h0000) begin
      $error("MAX_COUNT must be non-zero");
    end
  end

  // One byte of the reflected CRC-16 update
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ MBXR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Exception classification, in priority order
  function automatic logic [7:0] classify(input mbxr_req_t q, input logic [15:0] lim, input logic [15:0] cmax);
    logic        sup;
    logic [16:0] top;
    sup = (q.func == MBXR_FC_READ_HOLD) || (q.func == MBXR_FC_WRITE_ONE) || (q.func == MBXR_FC_WRITE_MANY);
    top = {1'b0, q.start_addr} + {1'b0, q.count};
    if (!sup) begin
      return MBXR_EXC_ILL_FUNC;
    end else if (q.start_addr > lim || top > {1'b0, lim} + 17'h00001) begin
      return MBXR_EXC_ILL_ADDR;
    end else if (q.len_bad || q.count > cmax) begin
      return MBXR_EXC_ILL_VAL;
    end else if (q.value_bad) begin
      return MBXR_EXC_DEV_FAIL;
    end
    return 8'h00;
  endfunction

  mbxr_state_t state, next_state;
  logic [7:0]  func_q, next_func_q;
  logic [7:0]  code_q, next_code_q;
  logic [7:0]  addr_q, next_addr_q;
  logic [15:0] crc, next_crc;
  logic [31:0] flt, next_flt;
  logic [1:0]  fidx, next_fidx;
  mbxr_tx_t    next_tx;
  logic        next_busy;
  logic        next_req_accepted;
  logic [15:0] next_wire_reg_addr;
  logic [7:0]  exc;

  // Sequencer next values; a byte leaves when the line side takes it
  always_comb begin
    next_state         = state;
    next_func_q        = func_q;
    next_code_q        = code_q;
    next_addr_q        = addr_q;
    next_crc           = crc;
    next_flt           = flt;
    next_fidx          = fidx;
    next_tx            = tx;
    next_req_accepted  = 1'b0;
    next_wire_reg_addr = doc_reg_num - MBXR_REG_OFFSET;
    exc                = classify(req, MAX_ADDR, MAX_COUNT);
    if (tx.valid && tx_ready) begin
      next_tx.valid = 1'b0;
    end
    case (state)
      MBXR_IDLE: begin
        if (req_valid && exc != 8'h00) begin
          next_req_accepted = 1'b1;
          next_func_q = req.func | MBXR_EXC_FLAG;
          next_code_q = exc;
          next_addr_q = own_addr;
          next_crc    = MBXR_CRC_SEED;
          next_state  = MBXR_ADDR;
        end else if (float_valid) begin
          // Reorder words and bytes as configured; default keeps top byte first
          case (float_order)
            MBXR_ORD_CDAB: next_flt = {float_value[15:0], float_value[31:16]};
            MBXR_ORD_BADC: next_flt = {float_value[23:16], float_value[31:24],
                                       float_value[7:0], float_value[15:8]};
            MBXR_ORD_DCBA: next_flt = {float_value[7:0], float_value[15:8],
                                       float_value[23:16], float_value[31:24]};
            default:       next_flt = float_value;
          endcase
          next_fidx  = 2'h0;
          next_state = MBXR_FLT;
        end
      end
      MBXR_ADDR: begin
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: 1'b0, data: addr_q};
          next_crc  = crc_byte(crc, addr_q);
          next_state = MBXR_FUNC;
        end
      end
      MBXR_FUNC: begin
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: 1'b0, data: func_q};
          next_crc  = crc_byte(crc, func_q);
          next_state = MBXR_CODE;
        end
      end
      MBXR_CODE: begin
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: 1'b0, data: code_q};
          next_crc  = crc_byte(crc, code_q);
          next_state = MBXR_CRCL;
        end
      end
      MBXR_CRCL: begin
        // The frame check is the one field always sent low byte first
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: 1'b0, data: crc[7:0]};
          next_state = MBXR_CRCH;
        end
      end
      MBXR_CRCH: begin
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: 1'b1, data: crc[15:8]};
          next_state = MBXR_IDLE;
        end
      end
      MBXR_FLT: begin
        if (!tx.valid || tx_ready) begin
          next_tx   = '{valid: 1'b1, last: (fidx == 2'h3), data: flt[31:24]};
          next_flt  = {flt[23:0], 8'h00};
          next_fidx = fidx + 2'h1;
          if (fidx == 2'h3) begin
            next_state = MBXR_IDLE;
          end
        end
      end
      default: next_state = MBXR_IDLE;
    endcase
    next_busy = (next_state != MBXR_IDLE) || next_tx.valid;
  end

  // State registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state         <= MBXR_IDLE;
      func_q        <= 8'h00;
      code_q        <= 8'h00;
      addr_q        <= 8'h00;
      crc           <= MBXR_CRC_SEED;
      flt           <= 32'h00000000;
      fidx          <= 2'h0;
      tx            <= '0;
      busy          <= 1'b0;
      req_accepted  <= 1'b0;
      wire_reg_addr <= 16'h0000;
    end else begin
      state         <= next_state;
      func_q        <= next_func_q;
      code_q        <= next_code_q;
      addr_q        <= next_addr_q;
      crc           <= next_crc;
      flt           <= next_flt;
      fidx          <= next_fidx;
      tx            <= next_tx;
      busy          <= next_busy;
      req_accepted  <= next_req_accepted;
      wire_reg_addr <= next_wire_reg_addr;
    end
  end

  // Checks
  a_exc_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx.valid && state == MBXR_CODE) |-> tx.data[7]) else $error("function byte lacks exception flag");
  a_func_unsupported: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && req_valid && req.func == 8'h01) |=> code_q == MBXR_EXC_ILL_FUNC)
    else $error("unsupported function not code 01");
  a_addr_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && req_valid && req.func == MBXR_FC_READ_HOLD && req.start_addr > MAX_ADDR)
    |=> code_q == MBXR_EXC_ILL_ADDR) else $error("bad address not code 02");
  a_len_bad: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && req_valid && req.func == MBXR_FC_WRITE_ONE && req.start_addr == 16'h0000
     && req.count == 16'h0001 && req.len_bad) |=> code_q == MBXR_EXC_ILL_VAL) else $error("bad length not code 03");
  a_value_limits: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && req_valid && req.func == MBXR_FC_WRITE_ONE && req.start_addr == 16'h0000
     && req.count == 16'h0001 && !req.len_bad && req.value_bad) |=> code_q == MBXR_EXC_DEV_FAIL)
    else $error("limit violation not code 04");
  a_float_default: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && !req_valid && float_valid && float_order == MBXR_ORD_ABCD)
    |=> flt == $past(float_value)) else $error("default float order not top byte first");
  a_float_swap: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && !req_valid && float_valid && float_order == MBXR_ORD_CDAB)
    |=> flt[31:16] == $past(float_value[15:0])) else $error("word swap not applied");
  a_reg_offset: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> wire_reg_addr == $past(doc_reg_num) - 16'h0001) else $error("register number not minus one");
  a_crc_seed: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_IDLE && req_valid && exc != 8'h00) |=> crc == 16'hFFFF) else $error("frame check not seeded");
  a_addr_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == MBXR_ADDR && (!tx.valid || tx_ready)) |=> tx.valid && tx.data == addr_q && state == MBXR_FUNC)
    else $error("reply does not open with own address");

endmodule
`default_nettype wire

// File: modbus_slave_exception_responder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_exception_responder_bench;
  import mbxr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        req_valid = 1'b0;
  mbxr_req_t   req = '0;
  logic [7:0]  own_addr = 8'h11;
  logic        float_valid = 1'b0;
  logic [31:0] float_value = 32'h425D47AE;
  logic [1:0]  float_order = 2'h0;
  logic [15:0] doc_reg_num = 16'h0000;
  logic        slow = 1'b0;
  wire [15:0]  wire_reg_addr;
  wire         tx_ready;
  mbxr_tx_t    tx;
  logic        busy;
  logic        req_accepted;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  mbxr_top uut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req(req), .own_addr(own_addr),
    .float_valid(float_valid), .float_value(float_value), .float_order(float_order),
    .doc_reg_num(doc_reg_num), .wire_reg_addr(wire_reg_addr), .tx_ready(tx_ready), .tx(tx),
    .busy(busy), .req_accepted(req_accepted));
  mbxr_master_model mdl (.clk_sys(clk_sys), .tx(tx), .slow(slow), .tx_ready(tx_ready));
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask
  // Bitwise reflected CRC, kept independent of the design's logic
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ MBXR_CRC_POLY) : (c >> 1);
    return c;
  endfunction
  // Bounded wait for the reply to drain
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk8({7'h00, busy}, 8'h00);
  endtask
  task automatic run_exc(input logic [7:0] fc, input logic [15:0] sa, input logic [15:0] cnt,
                         input logic lb, input logic vb, input logic [7:0] code);
    logic [15:0] crc;
    int          n;
    mdl.rx_q.delete();
    mdl.last_q.delete();
    @(negedge clk_sys);
    req = '{slave_addr: own_addr, func: fc, start_addr: sa, count: cnt, len_bad: lb, value_bad: vb};
    req_valid = 1'b1;
    n = 0;
    while (req_accepted !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    req_valid = 1'b0;
    wait_idle();
    crc = crc_step(crc_step(crc_step(MBXR_CRC_SEED, own_addr), fc | MBXR_EXC_FLAG), code);
    chk16(16'(mdl.rx_q.size()), 16'h0005);
    chk8(mdl.rx_q[0], own_addr);
    chk8(mdl.rx_q[1], fc | MBXR_EXC_FLAG);
    chk8(mdl.rx_q[2], code);
    chk8(mdl.rx_q[3], crc[7:0]);
    chk8(mdl.rx_q[4], crc[15:8]);
    chk8({7'h00, mdl.last_q[3]}, 8'h00);
    chk8({7'h00, mdl.last_q[4]}, 8'h01);
  endtask
  task automatic run_float(input logic [1:0] ord);
    logic [7:0] a, b, c, d;
    logic [31:0] e;
    int          n;
    {a, b, c, d} = float_value;
    case (ord)
      MBXR_ORD_ABCD: e = {a, b, c, d};
      MBXR_ORD_CDAB: e = {c, d, a, b};
      MBXR_ORD_BADC: e = {b, a, d, c};
      default:       e = {d, c, b, a};
    endcase
    mdl.rx_q.delete();
    mdl.last_q.delete();
    @(negedge clk_sys);
    float_order = ord;
    float_valid = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    float_valid = 1'b0;
    wait_idle();
    chk16(16'(mdl.rx_q.size()), 16'h0004);
    for (int i = 0; i < 4; i++) chk8(mdl.rx_q[i], e[31-8*i -: 8]);
    chk8({7'h00, mdl.last_q[2]}, 8'h00);
    chk8({7'h00, mdl.last_q[3]}, 8'h01);
  endtask
  task automatic run_map(input logic [15:0] num, input logic [15:0] exp);
    @(negedge clk_sys);
    doc_reg_num = num;
    @(negedge clk_sys);
    chk16(wire_reg_addr, exp);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    run_exc(8'h05, 16'h0000, 16'h0001, 1'b0, 1'b0, MBXR_EXC_ILL_FUNC);
    run_exc(8'h03, 16'h1000, 16'h0001, 1'b0, 1'b0, MBXR_EXC_ILL_ADDR);
    run_exc(8'h03, 16'h0FFF, 16'h0002, 1'b0, 1'b0, MBXR_EXC_ILL_ADDR);
    run_exc(8'h03, 16'h0000, 16'h007E, 1'b0, 1'b0, MBXR_EXC_ILL_VAL);
    run_exc(8'h10, 16'h0000, 16'h0001, 1'b1, 1'b0, MBXR_EXC_ILL_VAL);
    run_exc(8'h06, 16'h0000, 16'h0001, 1'b1, 1'b0, MBXR_EXC_ILL_VAL);
    run_exc(8'h06, 16'h0000, 16'h0001, 1'b0, 1'b1, MBXR_EXC_DEV_FAIL);
    slow = 1'b1;
    run_exc(8'h01, 16'h0000, 16'h0001, 1'b1, 1'b0, MBXR_EXC_ILL_FUNC);
    for (int o = 0; o < 4; o++) run_float(2'(o));
    slow = 1'b0;
    run_map(16'd1234, 16'd1233);
    run_map(16'h0001, 16'h0000);
    run_map(16'h0000, 16'hFFFF);
    complete_run();
  end
endmodule
`default_nettype wire
